// ---- verilog/underload_thermal_fault_logic.sv ----
`timescale 1ns/1ps
`include "fault_defs.svh"

module underload_thermal_fault_logic #(
   parameter int unsigned UNDERLOAD_DELAY_CYCLES = `UL_DELAY_US * `CORE_CLK_MHZ,
   parameter int unsigned CLEAR_INTERVAL_CYCLES  = `CLEAR_INTERVAL_US * `CORE_CLK_MHZ
) (
   // Clock, reset, enable
   input  wire logic                 CORE_CLK_I,
   input  wire logic                 RST_I,
   input  wire logic                 CE_I,
   // Device controls
   input  wire logic                 ENABLE_PIN_I,
   input  wire logic                 UNDERLOAD_SHUTDOWN_ENABLE_I,
   // Analog fault detectors
   input  wire fault_pkg::chan_t     UNDERLOAD_DETECT_I,
   input  wire fault_pkg::sensor_t   SENSOR_I,
   // Serial link
   input  wire logic                 CHIP_SELECT_LOW_I,
   input  wire logic                 SERIAL_CLK_I,
   input  wire logic                 SERIAL_DATA_I,
   output logic                      SERIAL_DATA_O,
   output logic                      SERIAL_DATA_OE_O,
   // Driver control and status
   output fault_pkg::chan_t          CHANNEL_OFF_O,
   output fault_pkg::status_t        STATUS_O,
   output logic                      CLEAR_BLOCKED_O
);
   import fault_pkg::*;

   localparam logic [`TIMER_W-1:0]   UL_LAST   = `TIMER_W'(UNDERLOAD_DELAY_CYCLES - 1);
   localparam logic [`TIMER_W-1:0]   CLR_LOAD  = `TIMER_W'(CLEAR_INTERVAL_CYCLES);
   localparam logic [`BIT_CNT_W-1:0] FRAME_LEN = `BIT_CNT_W'(`FRAME_BITS);

   core_state_t q;
   core_state_t d;
   link_evt_t   lk;
   logic        clear_now;

   //----------------------------------------------------------------
   // Serial pin sampling
   //----------------------------------------------------------------
   // Link pins enter through their own synchroniser
   link_sampler u_link (
      .clk_i             (CORE_CLK_I),
      .rst_i             (RST_I),
      .ce_i              (CE_I),
      .chip_select_low_i (CHIP_SELECT_LOW_I),
      .sclk_i            (SERIAL_CLK_I),
      .si_i              (SERIAL_DATA_I),
      .evt_o             (lk)
   );

   //----------------------------------------------------------------
   // Helpers
   //----------------------------------------------------------------
   // Saturating down-counter for the interval timer
   function automatic logic [`TIMER_W-1:0] count_down(input logic [`TIMER_W-1:0] v);
      count_down = (v == `TIMER_RST) ? `TIMER_RST : v - `TIMER_W'(1);
   endfunction

   // Outgoing frame: status first, one padding bit last
   function automatic logic [`FRAME_BITS-1:0] frame_word(input status_t s);
      frame_word = {s, 1'b0};
   endfunction

   // Shift one bit in at the bottom of a frame register
   function automatic logic [`FRAME_BITS-1:0] shift_in(input logic [`FRAME_BITS-1:0] v,
                                                        input logic                  b);
      shift_in = {v[`FRAME_BITS-2:0], b};
   endfunction

   // Hot channels stay latched until their sensor has cooled
   function automatic chan_t release_cool(input chan_t off, input chan_t cool);
      release_cool = off & ~cool;
   endfunction

   //----------------------------------------------------------------
   // Next state
   //----------------------------------------------------------------
   always_comb begin
      d         = q;
      clear_now = 1'b0;
      if (CE_I) begin
         //-------------------------------------------------------------
         // Input synchronisers
         //-------------------------------------------------------------
         d.s1  = SENSOR_I;
         d.s2  = q.s1;
         d.ul1 = UNDERLOAD_DETECT_I;
         d.ul2 = q.ul1;
         d.en1 = ENABLE_PIN_I;
         d.en2 = q.en1;

         //-------------------------------------------------------------
         // Serial frame
         //-------------------------------------------------------------
         if (lk.cs_fall) begin
            d.tx   = frame_word(q.live);
            d.so   = q.live.thermal_shutdown_flag;
            d.bits = '0;
            d.oe   = 1'b1;
         end
         if (!lk.cs_high && lk.sclk_rise) begin
            d.rx = shift_in(q.rx, lk.si);
            d.tx = shift_in(q.tx, 1'b0);
            if (q.bits != '1) begin
               d.bits = q.bits + `BIT_CNT_W'(1);
            end
         end
         if (!lk.cs_high && lk.sclk_fall) begin
            d.so = q.tx[`FRAME_BITS-1];
         end
         if (lk.cs_rise) begin
            d.oe = 1'b0;
            // Only whole frames count; interval timer blocks repeats
            clear_now = (q.bits == FRAME_LEN) && q.rx[`CLEAR_REQ_BIT]
                        && (q.clr_cnt == `TIMER_RST);
         end

         //-------------------------------------------------------------
         // Status reset request, clears before sets
         //-------------------------------------------------------------
         d.clr_cnt = count_down(q.clr_cnt);
         if (clear_now) begin
            d.clr_cnt                          = CLR_LOAD;
            d.live.underload_flag              = 1'b0;
            d.live.half_bridge_channel_status  = '0;
            d.ul_off                           = '0;
            d.tsd_off = release_cool(q.tsd_off, q.s2.under_shutdown_hyst);
         end

         //-------------------------------------------------------------
         // Shared underload delay
         //-------------------------------------------------------------
         if (|q.ul2) begin
            if (!q.ul_expired) begin
               if (q.ul_cnt == UL_LAST) begin
                  d.ul_expired = 1'b1;
               end else begin
                  d.ul_cnt = q.ul_cnt + `TIMER_W'(1);
               end
            end
         end else begin
            d.ul_cnt     = `TIMER_RST;
            d.ul_expired = 1'b0;
         end

         //-------------------------------------------------------------
         // Per-channel underload latch
         //-------------------------------------------------------------
         // Set after clear, so a persisting fault wins
         for (int ch = 0; ch < `NUM_CH; ch++) begin
            if (q.ul_expired && q.ul2[ch]) begin
               d.live.underload_flag = 1'b1;
               if (d.live.half_bridge_channel_status[ch] == `CH_STATUS_NONE) begin
                  d.live.half_bridge_channel_status[ch] = `CH_STATUS_UNDERLOAD;
               end
               if (UNDERLOAD_SHUTDOWN_ENABLE_I) begin
                  d.ul_off[ch] = 1'b1;
               end
            end
         end

         //-------------------------------------------------------------
         // Thermal warning and shutdown
         //-------------------------------------------------------------
         if (|q.s2.over_warn) begin
            d.live.thermal_warning_flag = 1'b1;
         end else if (&q.s2.under_warn_hyst) begin
            d.live.thermal_warning_flag = 1'b0;
         end
         d.tsd_off = d.tsd_off | q.s2.over_shutdown;
         if (|q.s2.over_shutdown) begin
            d.live.thermal_warning_flag = 1'b1;
         end

         //-------------------------------------------------------------
         // Enable pin low clears everything latched except the warning flag
         //-------------------------------------------------------------
         // Enable clear overrides the underload and shutdown sets above
         if (!q.en2) begin
            d.live.underload_flag             = 1'b0;
            d.live.half_bridge_channel_status = '0;
            d.ul_off                          = '0;
            d.tsd_off                         = '0;
            d.ul_cnt                          = `TIMER_RST;
            d.ul_expired                      = 1'b0;
         end
         d.live.thermal_shutdown_flag = |d.tsd_off;

         //-------------------------------------------------------------
         // Reported copy held while a frame is open
         //-------------------------------------------------------------
         if (lk.cs_high && !lk.cs_rise) begin
            d.shown = d.live;
         end
      end
   end

   //----------------------------------------------------------------
   // State register
   //----------------------------------------------------------------
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   //----------------------------------------------------------------
   // Outputs
   //----------------------------------------------------------------
   // Warning flag deliberately absent from the off terms
   assign CHANNEL_OFF_O    = q.ul_off | q.tsd_off;
   assign STATUS_O         = q.shown;
   assign SERIAL_DATA_O    = q.so;
   assign SERIAL_DATA_OE_O = q.oe;
   // Interval timer still running
   assign CLEAR_BLOCKED_O  = (q.clr_cnt != `TIMER_RST);

endmodule

// ---- verilog/fault_defs.svh ----
//
// Behaviour
// - Any channel underload starts one shared delay timer
// - Later underloads only wait the timer's remainder
// - Expired underload with enable: channel off, flag, 10
// - Enable low keeps drivers on past the delay
// - Reset request clears underload flag, status, re-activates
// - Any sensor above warning level sets warning flag
// - Warning flag clears itself below warning hysteresis
// - Warning never changes channel drive state
// - Shutdown level: channel off, warning kept, shutdown flag
// - Reset request clears shutdown once below hysteresis
// - Latched shutdown shown on serial out after select falls
// - Reset acted on at select rise; interval timer blocks repeats
// - Reported status frozen during frame, updated after
// - Enable pin low clears all latched status except the warning flag
`ifndef FAULT_DEFS_SVH
`define FAULT_DEFS_SVH

`define NUM_CH            6
`define FRAME_BITS        16
`define BIT_CNT_W         5
`define TIMER_W           16
`define CLEAR_REQ_BIT     15
`define CH_STATUS_NONE    2'h0
`define CH_STATUS_UNDERLOAD 2'h2

// Timing, times in microseconds, clock in MHz
`define CORE_CLK_MHZ      200
`define UL_DELAY_US       200
`define CLEAR_INTERVAL_US 100

// Reset values
`define CS_IDLE           1'h1
`define TIMER_RST         16'h0000

`endif

// ---- verilog/fault_pkg.sv ----
`include "fault_defs.svh"

package fault_pkg;

   typedef logic [`NUM_CH-1:0] chan_t;

   // Analog comparator outputs, one bit per channel
   typedef struct packed {
      chan_t over_warn;
      chan_t under_warn_hyst;
      chan_t over_shutdown;
      chan_t under_shutdown_hyst;
   } sensor_t;

   // Reported status, thermal shutdown first so it leads the frame
   typedef struct packed {
      logic                  thermal_shutdown_flag;
      logic                  thermal_warning_flag;
      logic                  underload_flag;
      logic [`NUM_CH-1:0][1:0] half_bridge_channel_status;
   } status_t;

   // Sampled serial link events
   typedef struct packed {
      logic cs_high;
      logic cs_fall;
      logic cs_rise;
      logic sclk_rise;
      logic sclk_fall;
      logic si;
   } link_evt_t;

   typedef struct packed {
      logic cs1;
      logic cs2;
      logic cs3;
      logic sck1;
      logic sck2;
      logic sck3;
      logic si1;
      logic si2;
   } sampler_state_t;

   typedef struct packed {
      sensor_t                  s1;
      sensor_t                  s2;
      chan_t                    ul1;
      chan_t                    ul2;
      logic                     en1;
      logic                     en2;
      logic [`TIMER_W-1:0]      ul_cnt;
      logic                     ul_expired;
      logic [`TIMER_W-1:0]      clr_cnt;
      chan_t                    ul_off;
      chan_t                    tsd_off;
      status_t                  live;
      status_t                  shown;
      logic [`FRAME_BITS-1:0]   tx;
      logic [`FRAME_BITS-1:0]   rx;
      logic [`BIT_CNT_W-1:0]    bits;
      logic                     so;
      logic                     oe;
   } core_state_t;

endpackage

// ---- verilog/link_sampler.sv ----
`timescale 1ns/1ps
`include "fault_defs.svh"

module link_sampler (
   // Clock and reset
   input  wire logic                 clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 ce_i,
   // Serial pins
   input  wire logic                 chip_select_low_i,
   input  wire logic                 sclk_i,
   input  wire logic                 si_i,
   // Events
   output fault_pkg::link_evt_t      evt_o
);
   import fault_pkg::*;

   localparam sampler_state_t RST_STATE = '{cs1: `CS_IDLE, cs2: `CS_IDLE,
                                            cs3: `CS_IDLE, default: 1'b0};

   sampler_state_t q;
   sampler_state_t d;

   always_comb begin
      d = q;
      if (ce_i) begin
         d.cs1  = chip_select_low_i;
         d.cs2  = q.cs1;
         d.cs3  = q.cs2;
         d.sck1 = sclk_i;
         d.sck2 = q.sck1;
         d.sck3 = q.sck2;
         d.si1  = si_i;
         d.si2  = q.si1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= RST_STATE;
      end else begin
         q <= d;
      end
   end

   // Edges seen only past the second stage
   always_comb begin
      evt_o.cs_high   = q.cs2;
      evt_o.cs_fall   = q.cs3 & ~q.cs2;
      evt_o.cs_rise   = ~q.cs3 & q.cs2;
      evt_o.sclk_rise = ~q.sck3 & q.sck2;
      evt_o.sclk_fall = q.sck3 & ~q.sck2;
      evt_o.si        = q.si2;
   end

endmodule

// ---- dv/fault_props.sv ----
`timescale 1ns/1ps

module fault_props (
   // Clock and reset
   input  wire logic               CORE_CLK_I,
   input  wire logic               RST_I,
   // Observed ports
   input  wire logic               ENABLE_PIN_I,
   input  wire logic               UNDERLOAD_SHUTDOWN_ENABLE_I,
   input  wire fault_pkg::sensor_t SENSOR_I,
   input  wire logic               CHIP_SELECT_LOW_I,
   input  wire logic               SERIAL_DATA_O,
   input  wire logic               SERIAL_DATA_OE_O,
   input  wire fault_pkg::chan_t   CHANNEL_OFF_O,
   input  wire fault_pkg::status_t STATUS_O,
   input  wire logic               CLEAR_BLOCKED_O
);
   import fault_pkg::*;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);

   a_oe_idle: assert property (CHIP_SELECT_LOW_I [*6] |-> !SERIAL_DATA_OE_O)
      else $error("serial out driven while idle");
   a_early_tsd: assert property ($fell(CHIP_SELECT_LOW_I) |-> ##4 SERIAL_DATA_OE_O
      && SERIAL_DATA_O == STATUS_O.thermal_shutdown_flag) else $error("early bit wrong");
   a_warn_set: assert property ((ENABLE_PIN_I && CHIP_SELECT_LOW_I
      && |SENSOR_I.over_warn) [*8] |-> STATUS_O.thermal_warning_flag) else $error("no warning");
   a_warn_clear: assert property ((CHIP_SELECT_LOW_I && &SENSOR_I.under_warn_hyst
      && !(|SENSOR_I.over_warn) && !(|SENSOR_I.over_shutdown)) [*8]
      |-> !STATUS_O.thermal_warning_flag) else $error("warning stuck");
   a_status_frozen: assert property ((!CHIP_SELECT_LOW_I) [*4] |-> $stable(STATUS_O))
      else $error("status moved inside frame");
   a_tsd_off: assert property ((ENABLE_PIN_I && |SENSOR_I.over_shutdown) [*8]
      |-> (CHANNEL_OFF_O & SENSOR_I.over_shutdown) == SENSOR_I.over_shutdown)
      else $error("hot channel left on");
   a_enable_clear: assert property ((!ENABLE_PIN_I && CHIP_SELECT_LOW_I) [*8]
      |-> CHANNEL_OFF_O == '0 && !STATUS_O.underload_flag && !STATUS_O.thermal_shutdown_flag)
      else $error("enable low kept faults");
   a_block_hold: assert property ($rose(CLEAR_BLOCKED_O) |-> CLEAR_BLOCKED_O [*8])
      else $error("interval too short");
   a_block_cause: assert property ($rose(CLEAR_BLOCKED_O)
      |-> CHIP_SELECT_LOW_I && $past(CHIP_SELECT_LOW_I, 3)) else $error("reset inside frame");
   a_off_cause: assert property ($rose(|CHANNEL_OFF_O) |-> $past(UNDERLOAD_SHUTDOWN_ENABLE_I)
      || $past(|SENSOR_I.over_shutdown, 3)) else $error("channel off without cause");
endmodule

bind underload_thermal_fault_logic fault_props u_props (
   .CORE_CLK_I                  (CORE_CLK_I),
   .RST_I                       (RST_I),
   .ENABLE_PIN_I                (ENABLE_PIN_I),
   .UNDERLOAD_SHUTDOWN_ENABLE_I (UNDERLOAD_SHUTDOWN_ENABLE_I),
   .SENSOR_I                    (SENSOR_I),
   .CHIP_SELECT_LOW_I           (CHIP_SELECT_LOW_I),
   .SERIAL_DATA_O               (SERIAL_DATA_O),
   .SERIAL_DATA_OE_O            (SERIAL_DATA_OE_O),
   .CHANNEL_OFF_O               (CHANNEL_OFF_O),
   .STATUS_O                    (STATUS_O),
   .CLEAR_BLOCKED_O             (CLEAR_BLOCKED_O)
);

// ---- dv/host_model.sv ----
`timescale 1ns/1ps

module host_model (
   // Serial pins
   output logic      csn_o,
   output logic      sclk_o,
   output logic      sdi_o,
   input  wire logic sdo_i
);
   initial begin
      csn_o = 1'b1;
      sclk_o = 1'b0;
      sdi_o = 1'b0;
   end
   // One frame, first bit carries the reset request
   task automatic frame(input logic clr, output logic early, output logic [15:0] rx);
      csn_o = 1'b0;
      #100 early = sdo_i;
      for (int i = 15; i >= 0; i--) begin
         sdi_o = (i == 15) ? clr : 1'b0;
         #62.5 sclk_o = 1'b1;
         rx[i] = sdo_i;
         #62.5 sclk_o = 1'b0;
      end
      sdi_o = 1'b0;
      #62.5 csn_o = 1'b1;
      #200;
   endtask
endmodule

// ---- dv/testbench.sv ----
`timescale 1ns/1ps

module testbench;
   import fault_pkg::*;
   logic        clk, rst, en, ulen, csn, sclk, sdi, sdo, oe, blk, early;
   chan_t       ul_det, off, ma, mb;
   sensor_t     sen;
   status_t     st;
   logic [15:0] rx;
   int          errors, comparisons, cycles, seed, a, b;

   underload_thermal_fault_logic #(.UNDERLOAD_DELAY_CYCLES(20),
      .CLEAR_INTERVAL_CYCLES(2000)) u_dut (
      .CORE_CLK_I(clk), .RST_I(rst), .CE_I(1'b1), .ENABLE_PIN_I(en),
      .UNDERLOAD_SHUTDOWN_ENABLE_I(ulen), .UNDERLOAD_DETECT_I(ul_det), .SENSOR_I(sen),
      .CHIP_SELECT_LOW_I(csn), .SERIAL_CLK_I(sclk), .SERIAL_DATA_I(sdi),
      .SERIAL_DATA_O(sdo), .SERIAL_DATA_OE_O(oe), .CHANNEL_OFF_O(off),
      .STATUS_O(st), .CLEAR_BLOCKED_O(blk));
   host_model u_host (.csn_o(csn), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 40000) begin
         errors++;
         final_report();
      end
   end

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask
   function automatic logic [14:0] es(input logic t, w, u, input chan_t m);
      for (int i = 0; i < 6; i++) es[2*i +: 2] = m[i] ? 2'h2 : 2'h0;
      es[14:12] = {t, w, u};
   endfunction
   task automatic xfer(input logic clr, input logic [14:0] e);
      u_host.frame(clr, early, rx);
      chk("early", {15'h0, e[14]}, {15'h0, early});
      chk("frame", {e, 1'b0}, rx);
   endtask
   task automatic chk_off(input chan_t e);
      chk("off", {10'h0, e}, {10'h0, off});
   endtask
   task automatic final_report();
      if (errors == 0 && comparisons > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   initial begin
      seed = 5707;
      rst = 1'b1;
      en = 1'b1;
      ulen = 1'b0;
      ul_det = '0;
      sen = '{over_warn: '0, under_warn_hyst: '1, over_shutdown: '0, under_shutdown_hyst: '1};
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      chk_off('0);
      a = {$random(seed)} % 6;
      b = (a + 1 + {$random(seed)} % 5) % 6;
      ma = chan_t'(1) << a;
      mb = chan_t'(1) << b;
      wt(4);
      sen.over_warn[a] = 1'b1;
      sen.under_warn_hyst[a] = 1'b0;
      wt(10);
      chk("warn", 16'h0001, {15'h0, st.thermal_warning_flag});
      chk_off('0);
      sen.over_warn[a] = 1'b0;
      wt(10);
      chk("warn", 16'h0001, {15'h0, st.thermal_warning_flag});
      sen.under_warn_hyst[a] = 1'b1;
      wt(10);
      chk("warn", 16'h0000, {15'h0, st.thermal_warning_flag});
      sen.over_shutdown[b] = 1'b1;
      sen.under_shutdown_hyst[b] = 1'b0;
      wt(10);
      chk_off(mb);
      xfer(1'b0, es(1'b1, 1'b1, 1'b0, '0));
      sen.over_shutdown[b] = 1'b0;
      wt(6);
      xfer(1'b1, es(1'b1, 1'b0, 1'b0, '0));
      wt(4);
      chk_off(mb);
      wt(2100);
      sen.under_shutdown_hyst[b] = 1'b1;
      xfer(1'b1, es(1'b1, 1'b0, 1'b0, '0));
      wt(6);
      chk_off('0);
      chk("blocked", 16'h0001, {15'h0, blk});
      sen.over_shutdown[a] = 1'b1;
      wt(10);
      sen.over_shutdown[a] = 1'b0;
      wt(6);
      xfer(1'b1, es(1'b1, 1'b0, 1'b0, '0));
      wt(6);
      chk_off(ma);
      wt(2100);
      xfer(1'b1, es(1'b1, 1'b0, 1'b0, '0));
      wt(6);
      chk_off('0);
      ulen = 1'b1;
      ul_det[a] = 1'b1;
      wt(10);
      ul_det[b] = 1'b1;
      wt(6);
      chk_off('0);
      wt(10);
      chk_off(ma | mb);
      xfer(1'b0, es(1'b0, 1'b0, 1'b1, ma | mb));
      wt(2100);
      xfer(1'b1, es(1'b0, 1'b0, 1'b1, ma | mb));
      wt(6);
      chk_off(ma | mb);
      ul_det = '0;
      wt(2100);
      xfer(1'b1, es(1'b0, 1'b0, 1'b1, ma | mb));
      wt(6);
      chk_off('0);
      xfer(1'b0, es(1'b0, 1'b0, 1'b0, '0));
      ulen = 1'b0;
      ul_det[b] = 1'b1;
      wt(40);
      chk_off('0);
      xfer(1'b0, es(1'b0, 1'b0, 1'b1, mb));
      en = 1'b0;
      ul_det = '0;
      wt(10);
      xfer(1'b0, es(1'b0, 1'b0, 1'b0, '0));
      final_report();
   end
endmodule
